//--- core/sosm_out_stage.sv
// Purpose: Serial output stage: resolution select, half-sample scramblers,
//          programmable bit mapper and lane serialiser, with an APB slave.
// Assumes: Samples arrive on pclk; link_clk is asynchronous and slow enough
//          that pclk sees every level (one lane bit per link clock edge).
// Notes:   Registers answer with one wait state; unmapped addresses error.
//
// Summary of operation
// (R01) Scrambling only in two-lanes-per-channel mode
// (R02) Scrambling needs DSP enable and scramble enable
// (R03) Upper and lower halves scrambled independently
// (R04) Output = input XOR outputs 14, 15 back
// (R05) No defined scrambler start state needed
// (R06) Halves enter scrambler LSB first
// (R07) Receiver descrambles each half separately
// (R08) Host maps one half per lane when scrambling
// (R09) Default two-lane map: odd/even bits split
// (R10) Host maps scrambled halves LSB first per lane
// (R11) Per-position register holds placed bit identifier
// (R12) Twenty bits per channel, previous and current
// (R13) Channel A previous identifiers per fixed table
// (R14) Current adds 0x40, channel B subtracts four
// (R15) Two-lane uses both sets; order per resolution
// (R16) Host may skip positions unused by resolution
// (R17) Mode selection reloads default identifiers everywhere
// (R18) Two, one, or half lane per channel
// (R19) Truncate for 14/16, append zeros for 20
// (R20) Scrambler history continuous across half-samples
`timescale 1ns/1ps
module sosm_out_stage
	import sosm_pkg::*;
#(
	parameter int LANES = NUM_LANES
)(
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Converter samples
	input  wire logic [SAMPLE_W-1:0] sample_a,
	input  wire logic [SAMPLE_W-1:0] sample_b,
	input  wire logic                sample_valid,
	// Link
	input  wire logic                link_clk,
	output logic      [LANES-1:0]    lane_data,
	output logic                     frame_clk
);

	// ==========================================================
	// Configuration and bit map registers
	sosm_cfg_type      cfg_q;
	sosm_cfg_type      cfg_d;
	logic [ID_W-1:0]   map_q [MAP_ENTRIES];
	logic [ID_W-1:0]   map_d [MAP_ENTRIES];
	logic              load_def;
	logic [9:0]        idx;
	logic              access;
	logic              wr;
	logic              map_hit;
	logic [9:0]        map_sel;
	logic              scr_active;

	assign idx     = paddr[ADDR_W-1:2];
	assign access  = psel & penable & pready;
	assign wr      = access & pwrite;
	assign map_sel = idx - IDX_MAP_BASE;
	assign map_hit = (idx >= IDX_MAP_BASE) && (map_sel < 10'(MAP_ENTRIES));

	// Scrambling only with both enables and in two-lane mode
	assign scr_active = cfg_q.dsp_en && cfg_q.scr_en && (cfg_q.mode == LM_TWO); // R01 R02

	// Configuration write decode; a lane mode write reloads the map
	always_comb begin
		cfg_d    = cfg_q;
		load_def = 1'b0;
		if (wr) begin
			case (idx)
				IDX_SCR_CFG: cfg_d.scr_en = pwdata[SCR_EN_BIT];   // R02
				IDX_DSP_CFG: cfg_d.dsp_en = pwdata[DSP_EN_BIT];   // R02
				IDX_CTRL: begin
					if (pwdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
						cfg_d.mode = sosm_lane_mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
						cfg_d.res  = sosm_res_type'(pwdata[CTRL_RES_LSB +: 2]);
						load_def   = 1'b1;                        // R17
					end
				end
				default: cfg_d = cfg_q;
			endcase
		end
	end

	// Per-position identifier writes and default reload
	always_comb begin
		for (int i = 0; i < MAP_ENTRIES; i++) begin
			if (load_def)
				map_d[i] = default_id(cfg_d.mode, cfg_d.res, i);  // R17 R09 R15
			else if (wr && map_hit && map_sel == 10'(i))
				map_d[i] = pwdata[ID_W-1:0];                      // R11
			else
				map_d[i] = map_q[i];
		end
	end

	// Configuration and map registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= '{mode: RST_MODE, res: RST_RES, dsp_en: RST_DSP_EN,
			           scr_en: RST_SCR_EN};
			for (int i = 0; i < MAP_ENTRIES; i++)
				map_q[i] <= default_id(RST_MODE, RST_RES, i);
		end else begin
			cfg_q <= cfg_d;
			for (int i = 0; i < MAP_ENTRIES; i++)
				map_q[i] <= map_d[i];
		end
	end

	// ==========================================================
	// APB answer: one wait state, read data and error registered
	logic        pready_d;
	logic        pslverr_d;
	logic [31:0] prdata_d;
	logic        decoded;

	always_comb begin
		pready_d  = psel & penable & ~pready;
		decoded   = map_hit || idx == IDX_SCR_CFG || idx == IDX_DSP_CFG ||
		            idx == IDX_CTRL || idx == IDX_STATUS;
		pslverr_d = pready_d & ~decoded;
		prdata_d  = '0;
		if (pready_d && !pwrite) begin
			case (idx)
				IDX_SCR_CFG: prdata_d[SCR_EN_BIT] = cfg_q.scr_en;
				IDX_DSP_CFG: prdata_d[DSP_EN_BIT] = cfg_q.dsp_en;
				IDX_CTRL: begin
					prdata_d[CTRL_MODE_LSB +: 2] = cfg_q.mode;
					prdata_d[CTRL_RES_LSB +: 2]  = cfg_q.res;
				end
				IDX_STATUS: begin
					prdata_d[STAT_SCR_BIT]       = scr_active;
					prdata_d[STAT_MODE_LSB +: 2] = cfg_q.mode;
					prdata_d[STAT_RES_LSB +: 2]  = cfg_q.res;
				end
				default: begin
					if (map_hit)
						prdata_d[ID_W-1:0] = map_q[map_sel[6:0]];
				end
			endcase
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= pready_d;
			pslverr <= pslverr_d;
			prdata  <= prdata_d;
		end
	end

	// ==========================================================
	// Resolution select, half split and scramblers
	logic [OUT_W-1:0]  sel_res [2];
	logic [OUT_W-1:0]  scr_out [2];
	logic [3:0]        half_len;
	logic [5:0]        nbits;

	assign nbits    = 6'(res_bits(cfg_q.res));
	assign half_len = nbits[4:1];

	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			logic [SAMPLE_W-1:0] raw;
			logic [OUT_W-1:0]    upper;
			logic [OUT_W-1:0]    lower;
			logic [HALF_MAX-1:0] up_s;
			logic [HALF_MAX-1:0] lo_s;

			assign raw = (c == 0) ? sample_a : sample_b;

			// Drop low bits for 14/16, pad two zeros for 20
			always_comb begin
				case (cfg_q.res)
					RES_14:  sel_res[c] = 20'(raw[SAMPLE_W-1:4]);    // R19
					RES_16:  sel_res[c] = 20'(raw[SAMPLE_W-1:2]);    // R19
					RES_18:  sel_res[c] = 20'(raw);
					default: sel_res[c] = {raw, 2'h0};               // R19
				endcase
			end

			// Split into upper and lower halves
			assign upper = sel_res[c] >> half_len;                   // R03
			assign lower = sel_res[c] & ((20'h1 << half_len) - 20'h1);

			sosm_scrambler #(.HALF_W(HALF_MAX)) u_scr_hi (
				.clk    (pclk),
				.rst_n  (presetn),
				.step   (sample_valid),
				.enable (scr_active),
				.len    (half_len),
				.din    (upper[HALF_MAX-1:0]),
				.dout   (up_s)
			);

			sosm_scrambler #(.HALF_W(HALF_MAX)) u_scr_lo (
				.clk    (pclk),
				.rst_n  (presetn),
				.step   (sample_valid),
				.enable (scr_active),
				.len    (half_len),
				.din    (lower[HALF_MAX-1:0]),
				.dout   (lo_s)
			);

			// Reassemble the scrambled halves
			assign scr_out[c] = (20'(up_s) << half_len) | 20'(lo_s);
		end
	endgenerate

	// ==========================================================
	// Previous and current sample pairs
	sosm_pair_type pair_q [2];
	sosm_pair_type pair_d [2];

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			pair_d[c] = pair_q[c];
			if (sample_valid)
				pair_d[c] = '{prev: pair_q[c].curr, curr: scr_out[c]}; // R12
		end
	end

	// Sample pair registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_q[0] <= '0;
			pair_q[1] <= '0;
		end else begin
			pair_q[0] <= pair_d[0];
			pair_q[1] <= pair_d[1];
		end
	end

	// Fetch the sample bit named by one identifier
	function automatic logic pick_bit(input logic [ID_W-1:0] id,
		input sosm_pair_type pa, input sosm_pair_type pb);
		int               b;
		logic [OUT_W-1:0] s;
		sosm_pair_type    p;
		b = 4 * int'(id[5:3]) + int'(id[1:0]) - 2;                 // R13
		p = id[ID_CHA_BIT] ? pa : pb;                              // R14
		s = id[ID_CUR_BIT] ? p.curr : p.prev;                      // R14
		if (b < 0 || b >= OUT_W)
			return 1'b0;
		return s[b];
	endfunction : pick_bit

	// ==========================================================
	// Link clock sampling and lane serialiser
	logic                   lk_s1_q;
	logic                   lk_s2_q;
	logic                   lk_last_q;
	logic                   link_edge;
	logic [5:0]             pos_q;
	logic [5:0]             pos_d;
	logic [5:0]             frame_len;
	logic [MAP_ENTRIES-1:0] live_bits;
	logic [MAP_ENTRIES-1:0] src_bits;
	logic [MAP_ENTRIES-1:0] frame_q;
	logic [MAP_ENTRIES-1:0] frame_d;
	logic [LANES-1:0]       lane_d;
	logic                   fclk_d;

	assign link_edge = lk_s2_q ^ lk_last_q;
	assign frame_len = (cfg_q.mode == LM_HALF) ? 6'(2 * nbits) : nbits;

	// Mapped frame bits from the current sample pairs
	always_comb begin
		for (int e = 0; e < MAP_ENTRIES; e++)
			live_bits[e] = pick_bit(map_q[e], pair_q[0], pair_q[1]);   // R11
	end

	// One lane bit per link clock edge, frame captured at position zero
	always_comb begin
		src_bits  = (pos_q == 6'h0) ? live_bits : frame_q;
		frame_d   = frame_q;
		pos_d     = pos_q;
		lane_d    = lane_data;
		fclk_d    = frame_clk;
		if (link_edge) begin
			frame_d = src_bits;
			pos_d   = (pos_q >= frame_len - 6'h1) ? 6'h0 : pos_q + 6'h1;
			fclk_d  = (pos_q < {1'b0, frame_len[5:1]});
			lane_d  = '0;
			case (cfg_q.mode)
				LM_TWO: begin                                          // R18 R15
					for (int l = 0; l < LANES; l++)
						lane_d[l] = src_bits[l * POS_PER_LANE + int'(pos_q)];
				end
				LM_ONE: begin                                          // R18
					lane_d[0] = src_bits[int'(pos_q)];
					lane_d[1] = src_bits[POS_PER_LANE + int'(pos_q)];
				end
				LM_HALF: lane_d[0] = src_bits[int'(pos_q)];            // R18
				default: lane_d = '0;
			endcase
			if (pos_q >= frame_len)
				lane_d = '0;
		end
		// A new mode restarts the frame; lanes only move on a link edge
		if (load_def) begin
			pos_d  = 6'h0;
		end
	end

	// Link synchroniser and serialiser registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_s1_q   <= 1'b0;
			lk_s2_q   <= 1'b0;
			lk_last_q <= 1'b0;
			pos_q     <= 6'h0;
			frame_q   <= '0;
			lane_data <= '0;
			frame_clk <= 1'b0;
		end else begin
			lk_s1_q   <= link_clk;
			lk_s2_q   <= lk_s1_q;
			lk_last_q <= lk_s2_q;
			pos_q     <= pos_d;
			frame_q   <= frame_d;
			lane_data <= lane_d;
			frame_clk <= fclk_d;
		end
	end

endmodule : sosm_out_stage

//--- core/sosm_pkg.sv
// Purpose: Shared constants, types and default-map function for the serial
//          output stage (resolution select, scrambler, bit mapper, lanes).
// Assumes: Register indices times four give APB byte addresses.
// Notes:   Bit identifiers are seven bits: current flag, group, channel A flag,
//          low pair.
package sosm_pkg;

	// ==========================================================
	// Geometry
	localparam int NUM_LANES    = 4;
	localparam int POS_PER_LANE = 20;
	localparam int MAP_ENTRIES  = 80;
	localparam int ID_W         = 7;
	localparam int SAMPLE_W     = 18;
	localparam int OUT_W        = 20;
	localparam int HALF_MAX     = 10;
	localparam int HIST_W       = 15;
	localparam int TAP_NEAR     = 14;
	localparam int TAP_FAR      = 15;
	localparam int ADDR_W       = 12;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [9:0] IDX_SCR_CFG  = 10'h022;
	localparam logic [9:0] IDX_DSP_CFG  = 10'h024;
	localparam logic [9:0] IDX_CTRL     = 10'h030;
	localparam logic [9:0] IDX_STATUS   = 10'h031;
	localparam logic [9:0] IDX_MAP_BASE = 10'h100;

	// ==========================================================
	// Field positions
	localparam int SCR_EN_BIT    = 6;
	localparam int DSP_EN_BIT    = 2;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RES_LSB  = 2;
	localparam int STAT_SCR_BIT  = 0;
	localparam int STAT_MODE_LSB = 1;
	localparam int STAT_RES_LSB  = 3;
	localparam int ID_CUR_BIT    = 6;
	localparam int ID_CHA_BIT    = 2;

	// ==========================================================
	// Modes and carriers
	typedef enum logic [1:0] {
		LM_TWO  = 2'h0,
		LM_ONE  = 2'h1,
		LM_HALF = 2'h2
	} sosm_lane_mode_type;

	typedef enum logic [1:0] {
		RES_14 = 2'h0,
		RES_16 = 2'h1,
		RES_18 = 2'h2,
		RES_20 = 2'h3
	} sosm_res_type;

	typedef struct packed {
		sosm_lane_mode_type mode;
		sosm_res_type       res;
		logic               dsp_en;
		logic               scr_en;
	} sosm_cfg_type;

	typedef struct packed {
		logic [OUT_W-1:0] prev;
		logic [OUT_W-1:0] curr;
	} sosm_pair_type;

	// ==========================================================
	// Reset values
	localparam sosm_lane_mode_type RST_MODE   = LM_TWO;
	localparam sosm_res_type       RST_RES    = RES_18;
	localparam logic               RST_DSP_EN = 1'b0;
	localparam logic               RST_SCR_EN = 1'b0;

	// Bits per sample for a resolution code
	function automatic int res_bits(input sosm_res_type res);
		return 14 + 2 * int'(res);
	endfunction : res_bits

	// Default identifier for one flat map entry after a mode selection
	function automatic logic [ID_W-1:0] default_id(input sosm_lane_mode_type mode,
		input sosm_res_type res, input int e);
		int n;
		int lane;
		int p;
		int k;
		int b;
		logic cur;
		logic cha;
		logic ok;
		n    = res_bits(res);
		lane = e / POS_PER_LANE;
		p    = e % POS_PER_LANE;
		cur  = 1'b1;
		cha  = 1'b1;
		ok   = 1'b0;
		b    = 0;
		case (mode)
			LM_TWO: begin
				cha = (lane < 2);
				cur = (p >= n / 2);
				k   = cur ? p - n / 2 : p;
				ok  = (p < n);
				b   = n - 1 - 2 * k - ((lane % 2 == 0) ? 0 : 1);
			end
			LM_ONE: begin
				cha = (lane == 0);
				ok  = (lane < 2) && (p < n);
				b   = n - 1 - p;
			end
			LM_HALF: begin
				cha = (e < n);
				ok  = (e < 2 * n);
				b   = cha ? n - 1 - e : 2 * n - 1 - e;
			end
			default: ok = 1'b0;
		endcase
		if (!ok || b < 0)
			return '0;
		return {cur, 3'((b + 2) / 4), cha, 2'((b + 2) % 4)};
	endfunction : default_id

endpackage : sosm_pkg

//--- core/sosm_scrambler.sv
// Purpose: One self-synchronising scrambler for one half-sample stream.
// Assumes: One half-sample per step, up to HALF_W bits, LSB first.
// Notes:   History carries across half-samples; reset clears it, though no defined start is needed.
`timescale 1ns/1ps
module sosm_scrambler
	import sosm_pkg::*;
#(
	parameter int HALF_W = HALF_MAX
)(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Half-sample in and out
	input  wire logic              step,
	input  wire logic              enable,
	input  wire logic [3:0]        len,
	input  wire logic [HALF_W-1:0] din,
	output logic      [HALF_W-1:0] dout
);

	logic [HIST_W-1:0] hist_q;
	logic [HIST_W-1:0] hist_d;

	// ==========================================================
	// Serial recursion unrolled over one half-sample
	always_comb begin
		logic [HIST_W-1:0] h;
		logic              y;
		h      = hist_q;
		y      = 1'b0;
		dout   = din;
		for (int i = 0; i < HALF_W; i++) begin
			if (enable && i < int'(len)) begin                 // R06
				y       = din[i] ^ h[TAP_NEAR-1] ^ h[TAP_FAR-1];  // R04
				dout[i] = y;
				h       = {h[HIST_W-2:0], y};
			end
		end
		hist_d = (step && enable) ? h : hist_q;                // R20
	end

	// History register; start-up contents do not matter to the receiver
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hist_q <= '0;                                      // R05
		else
			hist_q <= hist_d;
	end

endmodule : sosm_scrambler

//--- testbench/sosm_out_stage_props.sv
// Purpose: Port checks on the serial output stage.
// Assumes: One pclk domain; the link clock is sampled as data.
// Notes:   Bound to every output stage instance.
`timescale 1ns/1ps
module sosm_out_stage_props
	import sosm_pkg::*;
#(
	parameter int LANES = NUM_LANES
)(
	// Clock and reset
	input wire logic             pclk,
	input wire logic             presetn,
	// APB
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	// Link
	input wire logic             link_clk,
	input wire logic [LANES-1:0] lane_data,
	input wire logic             frame_clk
);
	// ==========
	// Cycles since the link clock last moved, saturating
	logic       link_q;
	logic       link_d;
	logic [3:0] since_q;
	logic [3:0] since_d;

	always_comb begin
		link_d  = link_clk;
		since_d = since_q + {3'h0, since_q != 4'hf};
		if (link_clk != link_q)
			since_d = 4'h0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_q  <= 1'b0;
			since_q <= 4'hf;
		end else begin
			link_q  <= link_d;
			since_q <= since_d;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========
	// Assertions
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready not one cycle after access");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
		else $error("pready without access phase");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero outside read answer");
	a_lane_after_link: assert property (!$stable(lane_data) |-> since_q inside {[4'h1:4'h6]})
		else $error("lane bits moved without a link edge");
	a_frame_after_link: assert property (!$stable(frame_clk) |-> since_q inside {[4'h1:4'h6]})
		else $error("frame clock moved without a link edge");
	a_frame_high_min: assert property ($rose(frame_clk) |=> frame_clk [*8])
		else $error("frame clock high too briefly");
endmodule : sosm_out_stage_props

bind sosm_out_stage sosm_out_stage_props #(.LANES(LANES)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
	.lane_data(lane_data), .frame_clk(frame_clk)
);

//--- testbench/sosm_out_stage_tb.sv
// Purpose: Self-checking bench for the serial output stage.
// Assumes: APB answers in bounded time; free link clock of 48 ns.
// Notes:   Receiver model rebuilds scrambled channel A samples.
`timescale 1ns/1ps
module sosm_out_stage_tb
	import sosm_pkg::*;
;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] exp;
		logic        err;
	} sosm_row_type;

	// ==========
	// Signals
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic                sample_valid, link_clk, frame_clk, err_v;
	logic [ADDR_W-1:0]   paddr;
	logic [31:0]         pwdata, prdata, rd_v;
	logic [SAMPLE_W-1:0] sample_a, sample_b, rx_prev, rx_curr;
	logic [3:0]          lane_data;
	int                  rx_count, mismatches, total_checks, c;
	// Reset contents: address in, data and error out
	sosm_row_type        rows [12] = '{
		'{12'h400, 32'h27, 1'b0}, '{12'h404, 32'h25, 1'b0},
		'{12'h424, 32'h67, 1'b0}, '{12'h448, 32'h00, 1'b0},
		'{12'h450, 32'h26, 1'b0}, '{12'h470, 32'h06, 1'b0},
		'{12'h4a0, 32'h23, 1'b0}, '{12'h4f0, 32'h22, 1'b0},
		'{12'h0c4, 32'h10, 1'b0}, '{12'h0c0, 32'h08, 1'b0},
		'{12'h088, 32'h00, 1'b0}, '{12'h7fc, 32'h00, 1'b1}
	};

	sosm_out_stage DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_a(sample_a), .sample_b(sample_b), .sample_valid(sample_valid),
		.link_clk(link_clk), .lane_data(lane_data), .frame_clk(frame_clk)
	);
	sosm_rx_model u_rx (
		.lane_data(lane_data), .link_clk(link_clk), .frame_clk(frame_clk),
		.rx_prev(rx_prev), .rx_curr(rx_curr), .rx_count(rx_count)
	);

	// ==========
	// Clocks and watchdog
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		link_clk = 1'b0;
		#7.3;
		forever #24 link_clk = ~link_clk;
	end
	initial begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		results();
	end

	// ==========
	// Tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One APB transfer; held until pready is seen high or 50 cycles pass
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50)
			mismatches++;
	endtask : apb

	task automatic wait_frame();
		int n;
		logic last;
		last = frame_clk;
		for (n = 0; n < 300; n++) begin
			@(posedge pclk);
			if (frame_clk === 1'b1 && last === 1'b0)
				break;
			last = frame_clk;
		end
		if (n == 300)
			mismatches++;
	endtask : wait_frame

	// Identifier of a half-sample bit, lane 0/2 upper half, lane 1/3 lower half
	function automatic logic [31:0] map_id(input int l, input int p);
		int b;
		b = (l % 2 == 0 ? 9 : 0) + p % 9;
		return {25'h0, p >= 9, 3'((b + 2) / 4), l < 2, 2'((b + 2) % 4)};
	endfunction : map_id

	function automatic logic [SAMPLE_W-1:0] smp(input int i);
		return SAMPLE_W'(i * 32'h1357b + 32'h0a5c3);
	endfunction : smp

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// ==========
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, sample_valid} = 5'h0;
		paddr = '0;
		pwdata = '0;
		sample_a = '0;
		sample_b = '0;
		mismatches = 0;
		total_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].addr, 32'h0);
			check($sformatf("word %h", rows[i].addr), rows[i].exp, rd_v);
			check("error", {31'h0, rows[i].err}, {31'h0, err_v});
		end
		$display("test reset done");
		apb(1'b1, 12'h088, 32'h40);
		apb(1'b0, 12'h0c4, 32'h0);
		check("status", 32'h10, rd_v);
		apb(1'b1, 12'h090, 32'h4);
		apb(1'b0, 12'h0c4, 32'h0);
		check("status", 32'h11, rd_v);
		for (int l = 0; l < 4; l++)
			for (int p = 0; p < 18; p++)
				apb(1'b1, 12'(1024 + 4 * (l * 20 + p)), map_id(l, p));
		apb(1'b0, 12'h400, 32'h0);
		check("map 0", 32'h17, rd_v);
		// Two samples per frame; a frame carries the pair sent one frame earlier
		for (int f = 0; f < 8; f++) begin
			wait_frame();
			sample_valid <= 1'b1;
			sample_a <= smp(2 * f);
			sample_b <= ~smp(2 * f);
			@(posedge pclk);
			sample_a <= smp(2 * f + 1);
			sample_b <= ~smp(2 * f + 1);
			@(posedge pclk);
			sample_valid <= 1'b0;
			c = rx_count;
			for (int n = 0; n < 300 && rx_count == c; n++)
				@(posedge pclk);
			if (rx_count == c)
				mismatches++;
			if (f >= 2) begin
				check("rx prev", 32'(smp(2 * f - 2)), 32'(rx_prev));
				check("rx curr", 32'(smp(2 * f - 1)), 32'(rx_curr));
			end
		end
		$display("test scramble done");
		apb(1'b1, 12'h0c0, 32'h9);
		apb(1'b0, 12'h0c4, 32'h0);
		check("status", 32'h12, rd_v);
		apb(1'b0, 12'h400, 32'h0);
		check("map 0", 32'h67, rd_v);
		apb(1'b1, 12'h0c0, 32'ha);
		apb(1'b1, 12'h0c0, 32'hb);
		apb(1'b0, 12'h0c0, 32'h0);
		check("ctrl", 32'ha, rd_v);
		apb(1'b0, 12'h448, 32'h0);
		check("map 18", 32'h63, rd_v);
		// Other resolutions reorder and trim the two-lane defaults
		apb(1'b1, 12'h0c0, 32'hc);
		apb(1'b0, 12'h428, 32'h0);
		check("map 10", 32'h6d, rd_v);
		apb(1'b1, 12'h0c0, 32'h4);
		apb(1'b0, 12'h450, 32'h0);
		check("map 20", 32'h24, rd_v);
		apb(1'b1, 12'h0c0, 32'h0);
		apb(1'b0, 12'h41c, 32'h0);
		check("map 7", 32'h5f, rd_v);
		apb(1'b0, 12'h438, 32'h0);
		check("map 14", 32'h00, rd_v);
		apb(1'b1, 12'h0c0, 32'h8);
		apb(1'b0, 12'h400, 32'h0);
		check("map 0", 32'h27, rd_v);
		apb(1'b0, 12'h0c4, 32'h0);
		check("status", 32'h11, rd_v);
		$display("test modes done");
		// Reset in mid-run restores configuration and map
		apb(1'b1, 12'h400, 32'h11);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h0c4, 32'h0);
		check("status", 32'h10, rd_v);
		apb(1'b0, 12'h0c0, 32'h0);
		check("ctrl", 32'h8, rd_v);
		apb(1'b0, 12'h400, 32'h0);
		check("map 0", 32'h27, rd_v);
		$display("test reset again done");
		results();
	end
endmodule : sosm_out_stage_tb

//--- testbench/sosm_rx_model.sv
// Purpose: Receiver model: descrambles lanes 0 and 1, rebuilds samples.
// Assumes: Two-lane 18-bit frames, upper half on lane 0, lower on lane 1.
// Notes:   Each lane bit is taken 8 ns after the following link edge.
`timescale 1ns/1ps
module sosm_rx_model
	import sosm_pkg::*;
(
	// Link side
	input  wire logic [3:0]          lane_data,
	input  wire logic                link_clk,
	input  wire logic                frame_clk,
	// Samples rebuilt from the last frame
	output logic      [SAMPLE_W-1:0] rx_prev,
	output logic      [SAMPLE_W-1:0] rx_curr,
	output int                       rx_count
);
	logic [HIST_W-1:0]   hist_q [2];
	logic [SAMPLE_W-1:0] acc_q [2];
	logic                fc_q;
	logic                x;
	int                  pos_q;

	// Start contents are arbitrary; the stream overwrites them
	initial begin
		hist_q   = '{default: '0};
		acc_q    = '{default: '0};
		fc_q     = 1'b1;
		pos_q    = 100;
		rx_prev  = '0;
		rx_curr  = '0;
		rx_count = 0;
	end

	// A bit stands until shortly after the next link edge
	always @(link_clk) begin
		#8;
		if (frame_clk && !fc_q)
			pos_q = 0;
		fc_q = frame_clk;
		for (int l = 0; l < 2; l++) begin
			x = lane_data[l] ^ hist_q[l][TAP_NEAR-1] ^ hist_q[l][TAP_FAR-1];
			hist_q[l] = {hist_q[l][HIST_W-2:0], lane_data[l]};
			acc_q[l] = {x, acc_q[l][SAMPLE_W-1:1]};
		end
		if (pos_q == SAMPLE_W - 1) begin
			rx_prev = {acc_q[0][8:0], acc_q[1][8:0]};
			rx_curr = {acc_q[0][17:9], acc_q[1][17:9]};
			rx_count++;
		end
		pos_q++;
	end
endmodule : sosm_rx_model
